// [cfd_divider.sv]
// counter frequency divider with Avalon-MM register slave
//
// Register access over Avalon-MM and the address map were decided locally.
`default_nettype none
module cfd_divider
    import cfd_pkg::*;
#(
    parameter int unsigned DW = 24
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // ttl pins
    input  wire logic        source_pin,
    input  wire logic        gate_pin,
    output logic             div_out
);
    localparam int unsigned TW = 20;

    typedef struct packed {
        logic [1:0]    src_sync;
        logic [1:0]    gate_sync;
        logic          src_prev;
        logic          gate_prev;
        logic [31:0]   ctrl;
        logic [DW-1:0] divisor;
        logic [DW-1:0] count;
        cfd_state_type state;
        logic          out;
        logic          pulse_hold;
        logic          tc_seen;
        logic          ack;
        logic [31:0]   rdata;
    } cfd_st_type;

    cfd_st_type st_ff;
    cfd_st_type nxt_st;

    logic          tb_wave;
    logic [TW-1:0] half_period;
    cfd_tb_type    tb_sel;
    cfd_gate_type  gate_mode;
    logic          sel_level;
    logic          sel_edge;
    logic          gate_level;
    logic          gate_edge;
    logic          count_ok;
    logic          at_tc;
    logic          bus_req;
    logic [31:0]   wmask;

    assign tb_sel    = cfd_tb_type'(st_ff.ctrl[CTL_TB_LSB +: 3]);
    assign gate_mode = cfd_gate_type'(st_ff.ctrl[CTL_GATE_LSB +: 3]);

    // timebase table per variant; unsupported codes fall back to 100 kHz
    always_comb begin
        half_period = TW'(HP_100KHZ);
        if (st_ff.ctrl[CTL_VARIANT]) begin
            unique case (tb_sel)
                TB_SEL1: half_period = TW'(HP_20MHZ);
                default: half_period = TW'(HP_100KHZ);
            endcase
        end else begin
            unique case (tb_sel)
                TB_SEL1: half_period = TW'(HP_1MHZ);
                TB_SEL3: half_period = TW'(HP_10KHZ);
                TB_SEL4: half_period = TW'(HP_1KHZ);
                TB_SEL5: half_period = TW'(HP_100HZ);
                default: half_period = TW'(HP_100KHZ);
            endcase
        end
    end

    cfd_timebase #(
        .CW (TW)
    ) u_timebase (
        .clk         (clk),
        .rst         (rst),
        .half_period (half_period),
        .wave        (tb_wave)
    );

    // source selection and edge choice
    always_comb begin
        sel_level = (tb_sel == TB_EXT) ? st_ff.src_sync[1] : tb_wave;
        // rising by default, falling when the edge bit is set
        if (st_ff.ctrl[CTL_EDGE]) begin
            sel_edge = st_ff.src_prev & ~sel_level;
        end else begin
            sel_edge = ~st_ff.src_prev & sel_level;
        end
    end

    // gate qualification
    always_comb begin
        gate_level = 1'b1;
        gate_edge  = 1'b0;
        unique case (gate_mode)
            GATE_HIGH: gate_level = st_ff.gate_sync[1];
            GATE_LOW:  gate_level = ~st_ff.gate_sync[1];
            GATE_RISE: gate_edge  = ~st_ff.gate_prev & st_ff.gate_sync[1];
            GATE_FALL: gate_edge  = st_ff.gate_prev & ~st_ff.gate_sync[1];
            default:   gate_level = 1'b1;
        endcase
    end

    // level gates only hold the count, never clear it
    assign count_ok = (st_ff.state == ST_RUN) && gate_level && sel_edge;
    assign at_tc    = (st_ff.count == DW'(1));
    assign bus_req  = (avs_read | avs_write) & ~st_ff.ack;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[8*i +: 8] = {8{avs_byteenable[i]}};
        end
    end

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.src_sync  = {st_ff.src_sync[0], source_pin};
        nxt_st.gate_sync = {st_ff.gate_sync[0], gate_pin};
        nxt_st.src_prev  = sel_level;
        nxt_st.gate_prev = st_ff.gate_sync[1];
        nxt_st.ack       = bus_req;

        unique case (st_ff.state)
            ST_IDLE: begin
            end
            ST_ARM: begin
                // edge gates wait for their trigger after start
                if (gate_edge) begin
                    nxt_st.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (count_ok) begin
                    // pulse lasts until the next counted edge, one source period while the gate stays open
                    nxt_st.pulse_hold = 1'b0;
                    if (!st_ff.ctrl[CTL_TOGGLE]) begin
                        nxt_st.out = 1'b0;
                    end
                    if (at_tc) begin
                        nxt_st.count   = st_ff.divisor;
                        nxt_st.tc_seen = 1'b1;
                        if (st_ff.ctrl[CTL_TOGGLE]) begin
                            nxt_st.out = ~st_ff.out;
                        end else begin
                            nxt_st.out        = 1'b1;
                            nxt_st.pulse_hold = 1'b1;
                        end
                    end else begin
                        nxt_st.count = st_ff.count - DW'(1);
                    end
                end
            end
            default: nxt_st.state = ST_IDLE;
        endcase

        // register access, answered one cycle after the request
        nxt_st.rdata = st_ff.rdata;
        if (bus_req && avs_read) begin
            unique case (avs_address)
                OFS_CTRL:   nxt_st.rdata = st_ff.ctrl;
                OFS_DIV:    nxt_st.rdata = 32'(st_ff.divisor);
                OFS_STATUS: nxt_st.rdata = {29'h0, st_ff.tc_seen, st_ff.out,
                                            st_ff.state != ST_IDLE};
                default:    nxt_st.rdata = 32'h0000_0000;
            endcase
        end
        if (bus_req && avs_write) begin
            unique case (avs_address)
                OFS_CTRL: begin
                    nxt_st.ctrl = (st_ff.ctrl & ~wmask) | (avs_writedata & wmask);
                end
                OFS_DIV: begin
                    // a divisor below two is the writer's fault
                    nxt_st.divisor = DW'((32'(st_ff.divisor) & ~wmask)
                                         | (avs_writedata & wmask));
                end
                OFS_CMD: begin
                    if (avs_byteenable[0] && avs_writedata[CMD_STOP]) begin
                        nxt_st.state      = ST_IDLE;
                        nxt_st.count      = '0;
                        nxt_st.out        = 1'b0;
                        nxt_st.pulse_hold = 1'b0;
                    end else if (avs_byteenable[0] && avs_writedata[CMD_START]) begin
                        nxt_st.count      = st_ff.divisor;
                        // a terminal count in the restart cycle still leaves its mark
                        nxt_st.tc_seen    = count_ok && at_tc;
                        nxt_st.out        = 1'b0;
                        // a restart drops any pulse in progress
                        nxt_st.pulse_hold = 1'b0;
                        if (gate_mode == GATE_RISE || gate_mode == GATE_FALL) begin
                            nxt_st.state = ST_ARM;
                        end else begin
                            nxt_st.state = ST_RUN;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff         <= '0;
            st_ff.ctrl    <= CTRL_RST;
            st_ff.divisor <= DW'(DIV_RST);
            st_ff.state   <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata    = st_ff.rdata;
    assign avs_waitrequest = ~st_ff.ack;
    assign div_out         = st_ff.out;

    // assertions
    sequence s_tc_pulse;
        count_ok && at_tc && !st_ff.ctrl[CTL_TOGGLE] && !(bus_req && avs_write);
    endsequence

    a_pulse_rise: assert property (@(posedge clk) disable iff (rst)
        s_tc_pulse |=> div_out)
        else $error("pulse did not rise at terminal count");

    a_pulse_fall: assert property (@(posedge clk) disable iff (rst)
        (div_out && count_ok && !at_tc && !st_ff.ctrl[CTL_TOGGLE]) |=> !div_out)
        else $error("pulse outlived one source period");

    a_toggle_flip: assert property (@(posedge clk) disable iff (rst)
        (count_ok && at_tc && st_ff.ctrl[CTL_TOGGLE] && !(bus_req && avs_write))
        |=> div_out != $past(div_out))
        else $error("toggle output did not invert");

    a_reload_div: assert property (@(posedge clk) disable iff (rst)
        (count_ok && at_tc && !(bus_req && avs_write)) |=> st_ff.count == $past(st_ff.divisor))
        else $error("divisor not reloaded");

    a_count_down: assert property (@(posedge clk) disable iff (rst)
        (count_ok && !at_tc && !(bus_req && avs_write))
        |=> st_ff.count == $past(st_ff.count) - DW'(1))
        else $error("count did not step down");

    a_gate_hold: assert property (@(posedge clk) disable iff (rst)
        (st_ff.state == ST_RUN && !gate_level && !(bus_req && avs_write))
        |=> $stable(st_ff.count))
        else $error("count moved while gate inactive");

    a_stop_clear: assert property (@(posedge clk) disable iff (rst)
        (bus_req && avs_write && avs_address == OFS_CMD && avs_byteenable[0]
         && avs_writedata[CMD_STOP]) |=> st_ff.count == '0 && st_ff.state == ST_IDLE)
        else $error("stop did not clear the count");

    a_start_run: assert property (@(posedge clk) disable iff (rst)
        (bus_req && avs_write && avs_address == OFS_CMD && avs_byteenable[0]
         && avs_writedata[CMD_START] && !avs_writedata[CMD_STOP] && gate_mode == GATE_NONE)
        |=> st_ff.state == ST_RUN)
        else $error("start did not begin counting");

    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus not answered in one cycle");

    a_answer_once: assert property (@(posedge clk) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer stood longer than one cycle");

    a_idle_answer: assert property (@(posedge clk) disable iff (rst)
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer given without a request");

    // read data must survive until the next read answer
    a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
        !(bus_req && avs_read) |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    // edge-gated start waits in the armed state
    sequence s_arm_wait;
        st_ff.state == ST_ARM && !gate_edge && !(bus_req && avs_write);
    endsequence

    sequence s_arm_fire;
        st_ff.state == ST_ARM && gate_edge && !(bus_req && avs_write);
    endsequence

    a_arm_hold: assert property (@(posedge clk) disable iff (rst)
        s_arm_wait |=> st_ff.state == ST_ARM && $stable(st_ff.count) && $stable(div_out))
        else $error("armed counter moved before its gate edge");

    a_arm_fire: assert property (@(posedge clk) disable iff (rst)
        s_arm_fire |=> st_ff.state == ST_RUN)
        else $error("gate edge did not start the run");

    a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        (st_ff.state == ST_IDLE && !(bus_req && avs_write))
        |=> st_ff.state == ST_IDLE && $stable(div_out) && $stable(st_ff.count))
        else $error("stopped counter changed");

    a_hold_between: assert property (@(posedge clk) disable iff (rst)
        (st_ff.state == ST_RUN && !count_ok && !(bus_req && avs_write))
        |=> $stable(st_ff.count) && $stable(div_out))
        else $error("count or output moved without a counted edge");

    a_toggle_keep: assert property (@(posedge clk) disable iff (rst)
        (count_ok && !at_tc && st_ff.ctrl[CTL_TOGGLE] && !(bus_req && avs_write))
        |=> $stable(div_out))
        else $error("toggle output moved between terminal counts");

    a_pulse_hold: assert property (@(posedge clk) disable iff (rst)
        st_ff.pulse_hold |-> div_out)
        else $error("pulse dropped before the next counted edge");

    a_tc_sticky: assert property (@(posedge clk) disable iff (rst)
        (count_ok && at_tc) |=> st_ff.tc_seen)
        else $error("terminal count not recorded");
endmodule
`default_nettype wire

// [cfd_pkg.sv]
// constants and types for the counter frequency divider
`default_nettype none
package cfd_pkg;
    localparam int unsigned CLK_HZ = 200000000;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_DIV    = 4'h4;
    localparam logic [3:0] OFS_CMD    = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    // control field positions
    localparam int CTL_TB_LSB   = 0;
    localparam int CTL_EDGE     = 3;
    localparam int CTL_TOGGLE   = 4;
    localparam int CTL_GATE_LSB = 5;
    localparam int CTL_VARIANT  = 8;
    // command bits
    localparam int CMD_START = 0;
    localparam int CMD_STOP  = 1;
    // status bits
    localparam int STS_RUN  = 0;
    localparam int STS_OUT  = 1;
    localparam int STS_TCNT = 2;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DIV_RST  = 32'h0000_0002;
    // internal timebase frequencies in Hz
    localparam int unsigned TB_1MHZ   = 1000000;
    localparam int unsigned TB_100KHZ = 100000;
    localparam int unsigned TB_10KHZ  = 10000;
    localparam int unsigned TB_1KHZ   = 1000;
    localparam int unsigned TB_100HZ  = 100;
    localparam int unsigned TB_20MHZ  = 20000000;
    // half-period counts of each timebase in clk cycles
    localparam int unsigned HP_1MHZ   = CLK_HZ / (2 * TB_1MHZ);
    localparam int unsigned HP_100KHZ = CLK_HZ / (2 * TB_100KHZ);
    localparam int unsigned HP_10KHZ  = CLK_HZ / (2 * TB_10KHZ);
    localparam int unsigned HP_1KHZ   = CLK_HZ / (2 * TB_1KHZ);
    localparam int unsigned HP_100HZ  = CLK_HZ / (2 * TB_100HZ);
    localparam int unsigned HP_20MHZ  = CLK_HZ / (2 * TB_20MHZ);
    // timebase select codes; 0 picks the source pin
    typedef enum logic [2:0] {
        TB_EXT  = 3'b000,
        TB_SEL1 = 3'b001,
        TB_SEL2 = 3'b010,
        TB_SEL3 = 3'b011,
        TB_SEL4 = 3'b100,
        TB_SEL5 = 3'b101
    } cfd_tb_type;
    typedef enum logic [2:0] {
        GATE_NONE = 3'b000,
        GATE_HIGH = 3'b001,
        GATE_LOW  = 3'b010,
        GATE_RISE = 3'b011,
        GATE_FALL = 3'b100
    } cfd_gate_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARM  = 2'b01,
        ST_RUN  = 2'b10
    } cfd_state_type;
endpackage
`default_nettype wire

// [cfd_timebase.sv]
// internal timebase generator: square wave from a half-period count
`default_nettype none
module cfd_timebase
    import cfd_pkg::*;
#(
    parameter int unsigned CW = 20
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // half-period in clk cycles
    input  wire logic [CW-1:0] half_period,
    // square wave
    output logic               wave
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          wave;
    } cfd_tb_st_type;

    cfd_tb_st_type st_ff;
    cfd_tb_st_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt >= half_period - CW'(1)) begin
            nxt_st.cnt  = '0;
            nxt_st.wave = ~st_ff.wave;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wave = st_ff.wave;
endmodule
`default_nettype wire

// [cfd_ttl_model.sv]
// behavioural ttl source and gate driver standing at the divider pins
`default_nettype none
module cfd_ttl_model
    import cfd_pkg::*;
(
    // clock and control from the bench
    input  wire logic       clk,
    input  wire logic       src_en,
    input  wire logic [7:0] src_half,
    input  wire logic       gate_lvl,
    // ttl pins
    output logic            source_pin,
    output logic            gate_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_ff;

    // source stands low while disabled; bench keeps src_half at 2 or more
    always_ff @(posedge clk) begin
        if (!src_en) begin
            cnt_ff     <= 8'h00;
            source_pin <= 1'b0;
        end else if (cnt_ff == src_half - 8'h01) begin
            cnt_ff     <= 8'h00;
            source_pin <= ~source_pin;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    assign gate_pin = gate_lvl;
endmodule
`default_nettype wire

// [tb_counter_frequency_divider.sv]
// self-checking bench for the counter frequency divider
`default_nettype none
module tb_counter_frequency_divider
    import cfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int H = 6;
    localparam int P = 2 * H;

    logic        clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        source_pin, gate_pin, div_out, src_en, gate_lvl, prev_out, prev_src;
    int          fail_count, num_checks, cyc, rise_cnt, last_rise, last_fall;
    int          s_rise, s_fall, lag_r, lag_f;

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    cfd_divider u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .source_pin(source_pin), .gate_pin(gate_pin), .div_out(div_out));

    cfd_ttl_model u_ttl (.clk(clk), .src_en(src_en), .src_half(8'(H)), .gate_lvl(gate_lvl),
        .source_pin(source_pin), .gate_pin(gate_pin));

    // edge bookkeeping on the falling clock, away from the drivers
    always @(negedge clk) begin
        if (source_pin === 1'b1 && prev_src === 1'b0) s_rise = cyc;
        if (source_pin === 1'b0 && prev_src === 1'b1) s_fall = cyc;
        if (div_out === 1'b1 && prev_out === 1'b0) begin
            rise_cnt++;
            last_rise = cyc;
            lag_r = cyc - s_rise;
            lag_f = cyc - s_fall;
        end
        if (div_out === 1'b0 && prev_out === 1'b1) last_fall = cyc;
        prev_src = source_pin;
        prev_out = div_out;
        cyc++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        chk(32'(n < 50), 32'h1, "bus answer");
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q, exp, what);
    endtask

    task automatic wait_rise(input int lim);
        int c0, n;
        c0 = rise_cnt;
        for (n = 0; n < lim && rise_cnt == c0; n++) @(posedge clk);
        chk(32'(rise_cnt != c0), 32'h1, "output event");
    endtask

    task automatic t_reset;
        logic [31:0] q;
        chk(32'(div_out), 32'h0, "div_out after reset");
        rd_chk(OFS_CTRL, CTRL_RST, "ctrl reset");
        rd_chk(OFS_DIV, DIV_RST, "div reset");
        rd_chk(OFS_STATUS, 32'h0, "status reset");
        rd_chk(OFS_CMD, 32'h0, "cmd reads zero");
        wr(4'h2, 32'hFFFF_FFFF);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd_chk(4'h2, 32'h0, "unmapped read");
        rd_chk(OFS_STATUS, 32'h0, "status read-only");
        rd_chk(OFS_CTRL, CTRL_RST, "ctrl untouched");
        bus(1'b1, OFS_DIV, 32'hFFFF_FF05, 4'h1, q);
        rd_chk(OFS_DIV, 32'h0000_0005, "div lane mask");
    endtask

    // start, measure two output events, then stop and watch it stay quiet
    task automatic t_run(input logic [31:0] ctrl, input int n, input int per, input logic ext);
        int t0, k, lim;
        logic [31:0] q;
        k = ctrl[CTL_TOGGLE] ? 2 : 1;
        lim = 2 * k * n * per + 200;
        wr(OFS_CTRL, ctrl);
        wr(OFS_DIV, 32'(n));
        wr(OFS_CMD, 32'h1);
        wait_rise(lim);
        t0 = last_rise;
        wait_rise(lim);
        chk(32'(last_rise - t0), 32'(k * n * per), "period");
        chk(32'(last_fall - t0), 32'((k == 2 ? n : 1) * per), "high time");
        if (ext) chk(32'((ctrl[CTL_EDGE] ? lag_f : lag_r) < H), 32'h1, "edge");
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk({30'h0, q[STS_TCNT], q[STS_RUN]}, 32'h3, "status running");
        wr(OFS_CMD, 32'h3);
        t0 = rise_cnt;
        repeat (n * per + 20) @(posedge clk);
        chk(32'(rise_cnt - t0), 32'h0, "quiet after stop");
        if (k == 1) chk(32'(div_out), 32'h0, "low after stop");
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk({30'h0, q[STS_OUT], q[STS_RUN]}, 32'h0, "stopped");
    endtask

    task automatic t_gate(input int m);
        logic        idle;
        logic [31:0] q;
        int          c0;
        idle = (m == GATE_LOW) || (m == GATE_FALL);
        gate_lvl <= idle;
        wr(OFS_CTRL, 32'(m) << CTL_GATE_LSB);
        wr(OFS_DIV, 32'h2);
        wr(OFS_CMD, 32'h1);
        c0 = rise_cnt;
        repeat (6 * P) @(posedge clk);
        chk(32'(rise_cnt - c0), 32'h0, "held by gate");
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
        chk(32'(q[STS_RUN]), 32'h1, "armed");
        gate_lvl <= !idle;
        wait_rise(6 * P + 50);
        gate_lvl <= idle;
        c0 = rise_cnt;
        repeat (6 * P) @(posedge clk);
        chk(32'(rise_cnt != c0), 32'(m > 2), "gate removed");
        if (m <= 2) begin
            bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
            chk(32'(q[STS_OUT]), 32'h1, "pulse held by gate");
        end
        gate_lvl <= !idle;
        wait_rise(6 * P + 50);
        wr(OFS_CMD, 32'h2);
    endtask

    initial begin
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        src_en = 1'b0;
        gate_lvl = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        src_en <= 1'b1;
        @(posedge clk);
        t_reset;
        t_run(32'h0000_0000, 3, P, 1'b1);
        t_run(32'h0000_0008, 2, P, 1'b1);
        t_run(32'h0000_0018, 2, P, 1'b1);
        t_run(32'h0000_0010, 5, P, 1'b1);
        t_run(32'h0000_0001, 2, 2 * HP_1MHZ, 1'b0);
        t_run(32'h0000_0002, 2, 2 * HP_100KHZ, 1'b0);
        t_run(32'h0000_0101, 4, 2 * HP_20MHZ, 1'b0);
        t_run(32'h0000_0102, 2, 2 * HP_100KHZ, 1'b0);
        for (int m = 1; m <= 4; m++) t_gate(m);
        complete_run;
    end

    // the whole run needs about 27k cycles
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        complete_run;
    end
endmodule
`default_nettype wire
